/* verilog/efbel_top.sv */
// design: blocking, stage outputs, events and fault records, four stages
`timescale 1ns/1ns
`default_nettype none

module efbel_top
  import efbel_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cycle_tick,
  input wire logic [NUM_STAGES-1:0] ext_block,
  input wire logic [NUM_STAGES-1:0] pickup,
  input wire logic [NUM_STAGES-1:0] watt_pickup,
  input wire logic [NUM_STAGES-1:0] var_pickup,
  input wire logic inrush_en,
  input wire logic [13:0] inrush_limit,
  input wire logic [MEAS_W-1:0] harm2_mag,
  input wire logic [MEAS_W-1:0] fund_mag,
  input wire logic inverse_mode,
  input wire logic [TIMER_W-1:0] definite_delay,
  input wire logic [TIMER_W-1:0] inverse_delay,
  input wire logic [TIMER_W-1:0] inverse_min_delay,
  input wire logic [TIMER_W-1:0] release_delay,
  input wire logic [2*NUM_SIGS-1:0] event_mask [NUM_STAGES],
  input wire efbel_meas_t meas,
  input wire logic [TS_W-1:0] time_ms,
  input wire logic [2:0] setting_group,
  input wire efbel_gnd_t gnd_type,
  input wire logic [1:0] rd_stage,
  input wire logic [3:0] rd_age,
  output logic [NUM_STAGES-1:0] start,
  output logic [NUM_STAGES-1:0] trip,
  output logic [NUM_STAGES-1:0] blocked,
  output logic [1:0] condition [NUM_STAGES],
  output logic display_note,
  output logic evt_valid,
  output efbel_event_t evt_data,
  output logic [3:0] rec_count [NUM_STAGES],
  output efbel_record_t rd_data,
  output logic busy
);

  // ************************************************************
  // state
  // ************************************************************
  typedef struct packed {
    efbel_phase_t phase;
    logic [NUM_STAGES-1:0][NUM_SIGS-1:0] cur;
    logic [NUM_STAGES-1:0][NUM_SIGS-1:0] prev;
    logic [NUM_STAGES-1:0][TIMER_W-1:0] timer;
    logic [NUM_STAGES-1:0][TIMER_W-1:0] rel;
    logic [NUM_STAGES-1:0][TIMER_W-1:0] remain;
    logic [1:0] scan_stage;
    logic [2:0] scan_sig;
    efbel_meas_t snap;
    logic [TS_W-1:0] snap_ts;
    logic [2:0] snap_sg;
    efbel_gnd_t snap_gnd;
    logic evt_valid;
    efbel_event_t evt;
    logic note;
    logic [NUM_STAGES-1:0][3:0] wr_ptr;
    logic [NUM_STAGES-1:0][3:0] count;
    efbel_record_t rd;
  } efbel_state_t;

  efbel_state_t state_ff;
  efbel_state_t nxt_state;
  efbel_record_t rec_mem [NUM_STAGES][REC_DEPTH];
  logic rec_we;
  logic [1:0] rec_stage;
  logic [3:0] rec_slot;
  efbel_record_t rec_word;
  logic [NUM_STAGES-1:0] blk_now;
  logic inrush_blk;
  logic [TIMER_W-1:0] op_delay;

  // ************************************************************
  // helpers
  // ************************************************************
  // ratio test done by cross-multiplying, no divider needed
  function automatic logic ratio_reached(input logic [MEAS_W-1:0] harm,
                                         input logic [MEAS_W-1:0] fund,
                                         input logic [13:0] limit);
    logic [31:0] lhs;
    logic [31:0] rhs;
    lhs = 32'({harm}) * PCT_SCALE;
    rhs = 32'({fund}) * 32'({limit});
    return lhs >= rhs;
  endfunction

  function automatic logic [3:0] wrap_inc(input logic [3:0] v);
    return (v == 4'(REC_DEPTH - 1)) ? 4'h0 : v + 4'h1;
  endfunction

  // saturating count, so a long pick-up never wraps back under the delay
  function automatic logic [TIMER_W-1:0] sat_inc(
    input logic [TIMER_W-1:0] v);
    return (v == '1) ? v : v + 1'b1;
  endfunction

  // age 0 is the newest entry; the slot walks back from the write pointer
  function automatic logic [3:0] age_slot(input logic [3:0] wp,
                                          input logic [3:0] age);
    logic [4:0] back;
    back = 5'({wp}) + 5'(REC_DEPTH) - 5'({age}) - 5'h01;
    if (back >= 5'(REC_DEPTH)) begin
      back = back - 5'(REC_DEPTH);
    end
    return back[3:0];
  endfunction

  // ************************************************************
  // block sources and delay selection
  // ************************************************************
  always_comb begin
    // one inrush decision serves all stages, as they share one current
    inrush_blk = inrush_en && (fund_mag != '0) &&
                 ratio_reached(harm2_mag, fund_mag, inrush_limit);
    blk_now = ext_block | {NUM_STAGES{inrush_blk}};
    // inverse delay is computed upstream; only its floor is applied here
    // delays count program cycles; a zero delay trips on the first tick
    if (inverse_mode) begin
      op_delay = (inverse_delay < inverse_min_delay) ? inverse_min_delay
                                                     : inverse_delay;
    end else begin
      op_delay = definite_delay;
    end
  end

  // ************************************************************
  // next state
  // ************************************************************
  always_comb begin
    logic [TIMER_W-1:0] t_inc;
    logic on_edge;
    logic off_edge;
    logic [3:0] mbit;
    nxt_state = state_ff;
    t_inc = '0;
    on_edge = 1'b0;
    off_edge = 1'b0;
    mbit = '0;
    rec_we = 1'b0;
    rec_stage = state_ff.scan_stage;
    rec_slot = state_ff.wr_ptr[state_ff.scan_stage];
    rec_word = '0;
    nxt_state.evt_valid = 1'b0;
    nxt_state.note = 1'b0;
    // record read runs every clock, independent of the scan
    if (rd_age >= state_ff.count[rd_stage]) begin
      nxt_state.rd = '0;
    end else begin
      nxt_state.rd = rec_mem[rd_stage][age_slot(state_ff.wr_ptr[rd_stage],
                                                rd_age)];
    end
    unique case (state_ff.phase)
      EFBEL_IDLE: begin
        // a tick during a scan is ignored, so ticks need 29 clocks apart
        if (cycle_tick) begin
          // one snapshot per program cycle feeds every event and record of the scan
          nxt_state.snap = meas;
          nxt_state.snap_ts = time_ms;
          nxt_state.snap_sg = setting_group;
          nxt_state.snap_gnd = gnd_type;
          nxt_state.prev = state_ff.cur;
          for (int s = 0; s < NUM_STAGES; s++) begin
            t_inc = sat_inc(state_ff.timer[s]);
            nxt_state.cur[s] = '0;
            if (pickup[s] && !blk_now[s]) begin
              nxt_state.cur[s][SIG_START] = 1'b1;
              nxt_state.timer[s] = t_inc;
              nxt_state.rel[s] = '0;
              nxt_state.cur[s][SIG_TRIP] = (t_inc >= op_delay);
              nxt_state.remain[s] = (t_inc >= op_delay) ? '0
                                                        : op_delay - t_inc;
            end else begin
              // blocked pick-up or pick-up drop share the release path
              nxt_state.cur[s][SIG_BLOCK] = pickup[s] && blk_now[s];
              if (state_ff.timer[s] != '0) begin
                if (sat_inc(state_ff.rel[s]) >= release_delay) begin
                  nxt_state.timer[s] = '0;
                  nxt_state.rel[s] = '0;
                end else begin
                  nxt_state.rel[s] = sat_inc(state_ff.rel[s]);
                end
              end
            end
            nxt_state.cur[s][SIG_WSTART] =
              nxt_state.cur[s][SIG_START] && watt_pickup[s];
            nxt_state.cur[s][SIG_VSTART] =
              nxt_state.cur[s][SIG_START] && var_pickup[s];
            nxt_state.cur[s][SIG_WTRIP] =
              nxt_state.cur[s][SIG_TRIP] && watt_pickup[s];
            nxt_state.cur[s][SIG_VTRIP] =
              nxt_state.cur[s][SIG_TRIP] && var_pickup[s];
          end
          nxt_state.scan_stage = '0;
          nxt_state.scan_sig = '0;
          nxt_state.phase = EFBEL_SCAN;
        end
      end
      EFBEL_SCAN: begin
        // one signal per clock keeps a single event port with no queue
        on_edge = state_ff.cur[state_ff.scan_stage][state_ff.scan_sig] &&
                  !state_ff.prev[state_ff.scan_stage][state_ff.scan_sig];
        off_edge = !state_ff.cur[state_ff.scan_stage][state_ff.scan_sig] &&
                   state_ff.prev[state_ff.scan_stage][state_ff.scan_sig];
        // mask bit is sig*2+off: on edges even, off edges odd
        mbit = {state_ff.scan_sig, off_edge};
        nxt_state.evt.stage = state_ff.scan_stage;
        nxt_state.evt.sig = state_ff.scan_sig;
        nxt_state.evt.off = off_edge;
        nxt_state.evt.stamp = state_ff.snap_ts;
        nxt_state.evt.meas = state_ff.snap;
        nxt_state.evt_valid = (on_edge || off_edge) &&
          event_mask[state_ff.scan_stage][mbit];
        if (on_edge && state_ff.scan_sig == SIG_BLOCK) begin
          nxt_state.note = 1'b1;
        end
        // records ignore the event mask so the fault store stays complete
        if (on_edge && state_ff.scan_sig <= SIG_BLOCK) begin
          rec_we = 1'b1;
          rec_word.evt = nxt_state.evt;
          rec_word.remain = state_ff.remain[state_ff.scan_stage];
          rec_word.setting_group = state_ff.snap_sg;
          rec_word.gnd = state_ff.snap_gnd;
          nxt_state.wr_ptr[state_ff.scan_stage] =
            wrap_inc(state_ff.wr_ptr[state_ff.scan_stage]);
          // count stops at the depth while the pointer wraps over the oldest
          if (state_ff.count[state_ff.scan_stage] != 4'(REC_DEPTH)) begin
            nxt_state.count[state_ff.scan_stage] =
              state_ff.count[state_ff.scan_stage] + 4'h1;
          end
        end
        if (state_ff.scan_sig == SIG_LAST) begin
          nxt_state.scan_sig = '0;
          if (state_ff.scan_stage == 2'(NUM_STAGES - 1)) begin
            nxt_state.phase = EFBEL_IDLE;
          end else begin
            nxt_state.scan_stage = state_ff.scan_stage + 2'h1;
          end
        end else begin
          nxt_state.scan_sig = state_ff.scan_sig + 3'h1;
        end
      end
      default: begin
        nxt_state.phase = EFBEL_IDLE;
      end
    endcase
  end

  // ************************************************************
  // registers
  // ************************************************************
  always_ff @(posedge core_clk) begin
    if (srst) begin
      state_ff <= '0;
      state_ff.phase <= EFBEL_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ************************************************************
  // record store
  // ************************************************************
  // no reset on the store: the per-stage count hides stale slots
  always_ff @(posedge core_clk) begin
    if (rec_we) begin
      rec_mem[rec_stage][rec_slot] <= rec_word;
    end
  end

  // ************************************************************
  // outputs
  // ************************************************************
  always_comb begin
    for (int s = 0; s < NUM_STAGES; s++) begin
      start[s] = state_ff.cur[s][SIG_START];
      trip[s] = state_ff.cur[s][SIG_TRIP];
      blocked[s] = state_ff.cur[s][SIG_BLOCK];
      rec_count[s] = state_ff.count[s];
      if (state_ff.cur[s][SIG_TRIP]) begin
        condition[s] = COND_TRIP;
      end else if (state_ff.cur[s][SIG_START]) begin
        condition[s] = COND_START;
      end else if (state_ff.cur[s][SIG_BLOCK]) begin
        condition[s] = COND_BLOCKED;
      end else begin
        condition[s] = COND_NORMAL;
      end
    end
  end

  assign display_note = state_ff.note;
  assign evt_valid = state_ff.evt_valid;
  assign evt_data = state_ff.evt;
  assign rd_data = state_ff.rd;
  assign busy = (state_ff.phase == EFBEL_SCAN);

endmodule // efbel_top

`default_nettype wire

/* shared/efbel_pkg.sv */
// package: constants and carriers for the earth fault block and event logger
//
// Functional notes
// - block input sampled once at each program cycle start, used all cycle
// - second harmonic inrush block option, enable setting defaults to off
// - unblocked pick-up asserts start and begins trip delay timing
// - blocked pick-up asserts blocked instead of start, no trip timing
// - block during start drops start and runs release timing as pick-up drop
// - blocking gives display pulse and time-stamped block event with values
// - definite delay and inverse minimum-time delay both supported
// - event on every start, trip or blocked change, record on on edges only
// - per-event mask selects on edge, off edge or both for event output
// - four independent stages with start, trip, block and component events
// - events carry time stamp and measurement values of that moment
// - per stage circular store of twelve records, oldest overwritten
// - record written only on on edge of start, trip or blocked
// - record holds event, time in ms, currents, components, voltage, angle
// - record holds remaining trip time, setting group, earthing, pre-fault
// - condition readable as normal, started, tripped, blocked codes 0 to 3
package efbel_pkg;

  localparam int NUM_STAGES = 4;
  localparam int NUM_SIGS = 7;
  localparam int REC_DEPTH = 12;
  localparam int TIMER_W = 16;
  localparam int MEAS_W = 16;
  localparam int TS_W = 48;
  // external block lead time, kept by the far side
  localparam int BLOCK_MARGIN_MS = 5;
  // inrush limit is in 0.01 percent units of the fundamental
  localparam logic [31:0] PCT_SCALE = 32'h0000_2710;
  localparam logic [13:0] INRUSH_LIMIT_RST = 14'h0001;
  localparam logic INRUSH_EN_RST = 1'b0;
  // signal positions within a stage
  localparam logic [2:0] SIG_START = 3'h0;
  localparam logic [2:0] SIG_TRIP = 3'h1;
  localparam logic [2:0] SIG_BLOCK = 3'h2;
  localparam logic [2:0] SIG_WSTART = 3'h3;
  localparam logic [2:0] SIG_VSTART = 3'h4;
  localparam logic [2:0] SIG_WTRIP = 3'h5;
  localparam logic [2:0] SIG_VTRIP = 3'h6;
  localparam logic [2:0] SIG_LAST = 3'h6;
  // condition codes
  localparam logic [1:0] COND_NORMAL = 2'h0;
  localparam logic [1:0] COND_START = 2'h1;
  localparam logic [1:0] COND_TRIP = 2'h2;
  localparam logic [1:0] COND_BLOCKED = 2'h3;

  typedef enum logic [1:0] {
    EFBEL_UNEARTHED = 2'h0,
    EFBEL_COIL = 2'h1,
    EFBEL_EARTHED = 2'h2
  } efbel_gnd_t;

  typedef enum logic [1:0] {
    EFBEL_IDLE = 2'b01,
    EFBEL_SCAN = 2'b10
  } efbel_phase_t;

  typedef struct packed {
    logic [MEAS_W-1:0] pre_trig_cur;
    logic [MEAS_W-1:0] fault_cur;
    logic [MEAS_W-1:0] cap_cur;
    logic [MEAS_W-1:0] res_cur;
    logic [MEAS_W-1:0] u0_pct;
    logic [MEAS_W-1:0] u0_volt;
    logic [MEAS_W-1:0] angle;
    logic [MEAS_W-1:0] pre_fault_cur;
  } efbel_meas_t;

  typedef struct packed {
    logic [1:0] stage;
    logic [2:0] sig;
    logic off;
    logic [TS_W-1:0] stamp;
    efbel_meas_t meas;
  } efbel_event_t;

  typedef struct packed {
    efbel_event_t evt;
    logic [TIMER_W-1:0] remain;
    logic [2:0] setting_group;
    efbel_gnd_t gnd;
  } efbel_record_t;

endpackage

/* verification/efbel_top_sva.sv */
// checker: stage, event and record assertions on the top module ports
`timescale 1ns/1ns
`default_nettype none
// ****************
// checker module
// ****************
module efbel_top_sva
  import efbel_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic cycle_tick,
  input wire logic [NUM_STAGES-1:0] ext_block,
  input wire logic [NUM_STAGES-1:0] pickup,
  input wire logic [1:0] rd_stage,
  input wire logic [3:0] rd_age,
  input wire logic [NUM_STAGES-1:0] start,
  input wire logic [NUM_STAGES-1:0] trip,
  input wire logic [NUM_STAGES-1:0] blocked,
  input wire logic [1:0] condition [NUM_STAGES],
  input wire logic display_note,
  input wire logic evt_valid,
  input wire efbel_event_t evt_data,
  input wire logic [3:0] rec_count [NUM_STAGES],
  input wire efbel_record_t rd_data,
  input wire logic busy
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (srst);
  wire logic tk = cycle_tick && !busy;
  property p_take; tk |=> busy; endproperty
  a_take: assert property (p_take) else $error("tick not taken");
  // start, trip and blocked may move only after a taken tick, never mid-cycle
  property p_hold;
    !tk |=> $stable(start) && $stable(trip) && $stable(blocked);
  endproperty
  a_hold: assert property (p_hold) else $error("output moved");
  property p_busy; $rose(busy) |-> ##27 busy ##1 !busy; endproperty
  a_busy: assert property (p_busy) else $error("scan length");
  property p_excl; (start & blocked) == 4'h0; endproperty
  a_excl: assert property (p_excl) else $error("start and blocked");
  property p_blk; tk |=> ((start | trip) & $past(ext_block)) == 4'h0;
  endproperty
  a_blk: assert property (p_blk) else $error("start under block");
  property p_note;
    display_note |-> evt_data.sig == SIG_BLOCK && !evt_data.off &&
      blocked[evt_data.stage];
  endproperty
  a_note: assert property (p_note) else $error("note slot");
  property p_rd; !busy && rd_age >= rec_count[rd_stage] |=> rd_data == '0;
  endproperty
  a_rd: assert property (p_rd) else $error("empty slot read");
  property p_cond(int k);
    condition[k] == (trip[k] ? COND_TRIP : start[k] ? COND_START :
      blocked[k] ? COND_BLOCKED : COND_NORMAL);
  endproperty
  property p_start(int k);
    $rose(start[k]) |-> $past(pickup[k] && !ext_block[k]);
  endproperty
  property p_rec(int k);
    $changed(rec_count[k]) && !$past(srst) |->
      rec_count[k] == $past(rec_count[k]) + 4'h1 && rec_count[k] <= 4'hC;
  endproperty
  for (genvar g = 0; g < NUM_STAGES; g++) begin : g_st
    a_cond: assert property (p_cond(g)) else $error("condition");
    a_start: assert property (p_start(g)) else $error("start");
    a_rec: assert property (p_rec(g)) else $error("record count");
  end
  c_note: cover property (display_note);
  c_trip: cover property ($rose(trip[0]));
  c_full: cover property (rec_count[3] == 4'hC);
endmodule // efbel_top_sva
bind efbel_top efbel_top_sva u_sva (.*);
`default_nettype wire

/* verification/efbel_far.sv */
// partner: blocking matrix route and event buffer of the relay
`timescale 1ns/1ns
`default_nettype none
// ****************
// far side model
// ****************
module efbel_far
  import efbel_pkg::*;
(
  input wire logic core_clk,
  input wire logic srst,
  input wire logic [NUM_STAGES-1:0] blk_req,
  input wire logic evt_valid,
  input wire efbel_event_t evt_data,
  input wire logic display_note,
  output logic [NUM_STAGES-1:0] ext_block,
  output var int ev_n,
  output var int note_n,
  output efbel_event_t last
);
  // one matrix register: requests land long before any operate delay ends
  always_ff @(posedge core_clk) begin
    ext_block <= srst ? '0 : blk_req;
    if (srst) begin
      ev_n <= 0;
      note_n <= 0;
    end else begin
      ev_n <= ev_n + int'(evt_valid);
      note_n <= note_n + int'(display_note);
    end
    if (evt_valid) begin
      last <= evt_data;
    end
  end
endmodule // efbel_far
`default_nettype wire

/* verification/test_efbel_top.sv */
// testbench: stage outputs, events and fault records of four stages
`timescale 1ns/1ns
`default_nettype none
module test_efbel_top;
  import efbel_pkg::*;
  // ****************
  // signals
  // ****************
  logic core_clk = 1'b0;
  logic srst = 1'b1;
  logic cycle_tick = 1'b0;
  logic inrush_en = INRUSH_EN_RST;
  logic inverse_mode = 1'b0;
  logic [NUM_STAGES-1:0] blk_req = '0, pickup = '0;
  logic [NUM_STAGES-1:0] watt_pickup = '0, var_pickup = '0;
  logic [13:0] inrush_limit = INRUSH_LIMIT_RST;
  logic [MEAS_W-1:0] harm2_mag = '0, fund_mag = '0;
  logic [TIMER_W-1:0] definite_delay = 16'h0002, inverse_delay = 16'h0003;
  logic [TIMER_W-1:0] inverse_min_delay = 16'h0002, release_delay = 16'h0001;
  logic [2*NUM_SIGS-1:0] event_mask [NUM_STAGES] = '{default: 14'h3FFF};
  efbel_meas_t meas = {8{16'h0A5C}};
  logic [TS_W-1:0] time_ms = '0;
  logic [2:0] setting_group = 3'h5;
  efbel_gnd_t gnd_type = EFBEL_COIL;
  logic [1:0] rd_stage = 2'h0;
  logic [3:0] rd_age = 4'h0;
  wire logic [NUM_STAGES-1:0] start, trip, blocked, ext_block;
  wire logic [1:0] condition [NUM_STAGES];
  wire logic display_note, evt_valid, busy;
  wire efbel_event_t evt_data, last;
  wire logic [3:0] rec_count [NUM_STAGES];
  wire efbel_record_t rd_data;
  int ev_n, note_n, n0, m0, err_total = 0, checks = 0;
  logic [3:0] c0;
  efbel_top DUT (.*);
  efbel_far u_far (.*);
  always #50 core_clk = ~core_clk;
  always @(posedge core_clk) time_ms <= time_ms + 1'b1;
  // ****************
  // tasks
  // ****************
  task automatic cmp(input logic [63:0] got, input logic [63:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  // ticks spaced 32 cycles apart, clear of the 28 cycle scan
  task automatic tick(input int n = 1);
    repeat (n) begin
      @(posedge core_clk) cycle_tick <= 1'b1;
      @(posedge core_clk) cycle_tick <= 1'b0;
      repeat (30) @(posedge core_clk);
    end
  endtask
  task automatic conclude();
    $display("mismatches %0d comparisons %0d", err_total, checks);
    if (err_total == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ****************
  // tests
  // ****************
  initial begin
    repeat (16) @(posedge core_clk);
    srst <= 1'b0;
    @(posedge core_clk);
    cmp({start, trip, blocked, condition[0], rec_count[0]}, '0);
    pickup[0] <= 1'b1;
    watt_pickup[0] <= 1'b1;
    tick();
    cmp({start[0], condition[0]}, {1'b1, COND_START});
    cmp(ev_n, 2);
    cmp({last.stage, last.sig, last.off}, {2'h0, SIG_WSTART, 1'b0});
    cmp(last.meas.angle, meas.angle);
    cmp(rec_count[0], 4'h1);
    tick(2);
    cmp({trip[0], condition[0]}, {1'b1, COND_TRIP});
    cmp(ev_n, 4);
    cmp(rec_count[0], 4'h2);
    cmp({rd_data.evt.sig, rd_data.evt.off, rd_data.setting_group,
      rd_data.gnd}, {SIG_TRIP, 1'b0, 3'h5, EFBEL_COIL});
    cmp(rd_data.evt.meas.fault_cur, meas.fault_cur);
    cmp(rd_data.remain, '0);
    rd_age <= 4'h2;
    repeat (2) @(posedge core_clk);
    cmp(rd_data[63:0], 64'h0);
    blk_req[0] <= 1'b1;
    tick();
    cmp({start[0], trip[0]}, 2'h0);
    blk_req[0] <= 1'b0;
    pickup[0] <= 1'b0;
    watt_pickup[0] <= 1'b0;
    tick(2);
    cmp(condition[0], COND_NORMAL);
    blk_req[1] <= 1'b1;
    tick();
    n0 = ev_n;
    m0 = note_n;
    pickup[2:1] <= 2'h3;
    var_pickup[2] <= 1'b1;
    tick();
    cmp({blocked[1], start[1], start[2], condition[1]},
      {3'b101, COND_BLOCKED});
    cmp(note_n - m0, 1);
    cmp(ev_n - n0, 3);
    cmp({last.stage, last.sig}, {2'h2, SIG_VSTART});
    cmp(rec_count[1], 4'h1);
    pickup[2:1] <= 2'h0;
    var_pickup[2] <= 1'b0;
    blk_req[1] <= 1'b0;
    tick(2);
    // limit 15.00 % of 100: ratio 15 sits exactly on it, 14 is below
    fund_mag <= 16'h0064;
    inrush_limit <= 14'h05DC;
    for (int i = 0; i < 3; i++) begin
      inrush_en <= (i != 0);
      harm2_mag <= (i == 2) ? 16'h000E : 16'h000F;
      pickup[3] <= 1'b1;
      tick();
      cmp({start[3], blocked[3]}, (i == 1) ? 2'h1 : 2'h2);
      pickup[3] <= 1'b0;
      tick(2);
    end
    inrush_en <= 1'b0;
    event_mask[3] <= 14'h0000;
    n0 = ev_n;
    c0 = rec_count[3];
    pickup[3] <= 1'b1;
    tick();
    cmp(ev_n - n0, 0);
    cmp(rec_count[3], c0 + 4'h1);
    event_mask[3] <= 14'h2AAA;
    pickup[3] <= 1'b0;
    tick();
    cmp(ev_n - n0, 1);
    cmp({last.stage, last.sig, last.off}, {2'h3, SIG_START, 1'b1});
    event_mask[3] <= 14'h3FFF;
    repeat (12) begin
      pickup[3] <= 1'b1;
      tick();
      pickup[3] <= 1'b0;
      tick();
    end
    cmp(rec_count[3], 4'hC);
    rd_stage <= 2'h3;
    rd_age <= 4'hB;
    repeat (2) @(posedge core_clk);
    cmp({rd_data.evt.stage, rd_data.evt.sig}, {2'h3, SIG_START});
    // inverse mode: delay 3 first, then delay 1 floored at minimum 3
    inverse_mode <= 1'b1;
    pickup[0] <= 1'b1;
    for (int i = 0; i < 2; i++) begin
      tick(2);
      cmp({start[0], trip[0]}, 2'h2);
      tick();
      cmp(trip[0], 1'b1);
      inverse_delay <= 16'h0001;
      inverse_min_delay <= 16'h0003;
      pickup[0] <= 1'b0;
      tick();
      pickup[0] <= 1'b1;
    end
    conclude();
  end
  // about 53 ticks of 32 cycles are needed; allow near three times that
  initial begin
    repeat (5000) @(posedge core_clk);
    err_total++;
    conclude();
  end
endmodule // test_efbel_top
`default_nettype wire
